// file: hdl/mmba_consts.vh
`ifndef MMBA_CONSTS_VH
`define MMBA_CONSTS_VH

// --------------------------------------------------------------
// register map, byte addresses
// --------------------------------------------------------------
`define MMBA_ADDR_W      8
`define MMBA_REG_CTRL    8'h00
`define MMBA_REG_STATUS  8'h04
`define MMBA_REG_COUNT   8'h08

// control fields and reset value
`define MMBA_CTRL_RES    0
`define MMBA_CTRL_ANY    1
`define MMBA_CTRL_PBUSN  2
`define MMBA_CTRL_RST    3'h4

// --------------------------------------------------------------
// bus responses and processor status codes
// --------------------------------------------------------------
`define MMBA_RESP_OKAY   2'h0
`define MMBA_RESP_DECERR 2'h3
`define MMBA_ST_PASSIVE  3'h7
`define MMBA_ST_HALT     3'h3

`endif

// file: hdl/mmba_cycle.v
`include "mmba_consts.vh"

// --------------------------------------------------------------
// processor cycle tracker from decoded status lines
// --------------------------------------------------------------
module mmba_cycle (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [2:0] status,
	output wire       cycle_active,
	output wire       mem_cycle,
	output wire       halted,
	output wire       cycle_done
);
	reg       act_prev_r;
	reg       halt_r;

	// halt is not a transfer; passive marks the gap between cycles
	assign cycle_active = (status != `MMBA_ST_PASSIVE) && (status != `MMBA_ST_HALT);
	// interrupt acknowledge has bit two low, so it falls with IO
	assign mem_cycle    = cycle_active & status[2];
	assign cycle_done   = act_prev_r & ~cycle_active;
	assign halted       = halt_r;

	// halt stays remembered until the processor starts a new cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			act_prev_r <= 1'b0;
			halt_r     <= 1'b0;
		end else begin
			act_prev_r <= cycle_active;
			if (status == `MMBA_ST_HALT)
				halt_r <= 1'b1;
			else if (cycle_active)
				halt_r <= 1'b0;
		end
	end
endmodule // mmba_cycle

// file: hdl/mmba_sync.v
// --------------------------------------------------------------
// three-stage synchroniser with agreement filter
// --------------------------------------------------------------
module mmba_sync #(
	parameter             WIDTH = 1,
	parameter [WIDTH-1:0] INIT  = {WIDTH{1'b1}}
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] s1_r;
	reg [WIDTH-1:0] s2_r;
	reg [WIDTH-1:0] s3_r;
	reg [WIDTH-1:0] out_r;
	wire [WIDTH-1:0] agree;

	// only stages two and three are compared; stage one may be metastable
	assign agree = ~(s2_r ^ s3_r);

	// a bit changes once the last two stages agree
	always @(posedge clk) begin
		if (!rst_n) begin
			s1_r  <= INIT;
			s2_r  <= INIT;
			s3_r  <= INIT;
			out_r <= INIT;
		end else begin
			s1_r  <= d;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			out_r <= (s3_r & agree) | (out_r & ~agree);
		end
	end

	assign q = out_r;
endmodule // mmba_sync

// file: hdl/mmba_top.v
`include "mmba_consts.vh"

// --------------------------------------------------------------
// multi-master bus arbiter, device side
// --------------------------------------------------------------
module mmba_top #(
	parameter CNT_W = 16
) (
	input  wire        aclk,
	input  wire        aresetn,
	// register bus
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// local processor side
	input  wire        status_bit_two,
	input  wire        status_bit_one,
	input  wire        status_bit_zero,
	input  wire        proc_lock_n,
	input  wire        common_request_lock_n,
	input  wire        system_or_local_select,
	output wire        address_drive_enable_n,
	// shared bus side
	input  wire        bus_clk,
	input  wire        bus_init_n,
	input  wire        priority_in_n,
	output wire        bus_request_out_n,
	input  wire        busy_in,
	output wire        busy_out,
	output wire        busy_oe,
	input  wire        common_bus_request_n,
	output wire        common_bus_request_out,
	output wire        common_bus_request_oe
);
	// --------------------------------------------------------------
	// states
	// --------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_REQ  = 3'b010;
	localparam [2:0] ST_OWN  = 3'b100;

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	wire [10:0]      pins_s;
	wire             bclk_s;
	wire             pri_n_s;
	wire             busy_s;
	wire             common_bus_request_n_n_s;
	wire             lock_n_s;
	wire             common_request_lock_n_n_s;
	wire             sel_s;
	wire             init_n_s;
	wire [2:0]       stat_s;
	wire             cycle_active;
	wire             mem_cycle;
	wire             halted;
	wire             cycle_done;
	wire             bclk_fall;
	wire             res_mode;
	wire             any_mode;
	wire             io_mode;
	wire             sel_ok;
	wire             io_ok;
	wire             need_now;
	wire             common_bus_request_n_yield;
	wire             pri_yield;
	wire             surrender;
	wire             aw_take;
	wire             w_take;
	wire             wr_do;
	wire             ar_take;
	reg              bclk_prev_r;
	reg  [2:0]       state_r;
	reg  [2:0]       state_nxt;
	reg              bus_request_out_n_n_r;
	reg              aen_n_r;
	reg              busy_drv_r;
	reg              common_bus_request_n_drv_r;
	reg  [2:0]       ctrl_r;
	reg  [CNT_W-1:0] grant_cnt_r;
	reg              aw_full_r;
	reg  [7:0]       aw_addr_r;
	reg              w_full_r;
	reg  [31:0]      w_data_r;
	reg  [3:0]       w_strb_r;
	reg              bvalid_r;
	reg  [1:0]       bresp_r;
	reg              rvalid_r;
	reg  [1:0]       rresp_r;
	reg  [31:0]      rdata_r;

	// --------------------------------------------------------------
	// pin synchronisation
	// --------------------------------------------------------------
	// every processor and shared-bus pin crosses three stages and the filter register before use
	mmba_sync #(
		.WIDTH (11),
		.INIT  (11'h7FF)
	) u_sync (
		.clk   (aclk),
		.rst_n (aresetn),
		.d     ({bus_clk, priority_in_n, busy_in, common_bus_request_n,
		         proc_lock_n, common_request_lock_n, system_or_local_select,
		         bus_init_n, status_bit_two, status_bit_one, status_bit_zero}),
		.q     (pins_s)
	);

	assign bclk_s     = pins_s[10];
	assign pri_n_s    = pins_s[9];
	assign busy_s     = pins_s[8];
	assign common_bus_request_n_n_s   = pins_s[7];
	assign lock_n_s   = pins_s[6];
	assign common_request_lock_n_n_s = pins_s[5];
	assign sel_s      = pins_s[4];
	assign init_n_s   = pins_s[3];
	assign stat_s     = pins_s[2:0];

	// --------------------------------------------------------------
	// processor cycle tracking
	// --------------------------------------------------------------
	mmba_cycle u_cycle (
		.clk          (aclk),
		.rst_n        (aresetn),
		.status       (stat_s),
		.cycle_active (cycle_active),
		.mem_cycle    (mem_cycle),
		.halted       (halted),
		.cycle_done   (cycle_done)
	);

	// --------------------------------------------------------------
	// bus clock edge finder
	// --------------------------------------------------------------
	// shared-bus decisions other than initialisation are made only on a falling bus clock edge
	always @(posedge aclk) begin
		if (!aresetn)
			bclk_prev_r <= 1'b0;
		else
			bclk_prev_r <= bclk_s;
	end

	assign bclk_fall = bclk_prev_r & ~bclk_s;

	// --------------------------------------------------------------
	// mode decoding
	// --------------------------------------------------------------
	// straps are plain levels; software should change them only while idle
	assign res_mode = ctrl_r[`MMBA_CTRL_RES];
	assign any_mode = ctrl_r[`MMBA_CTRL_ANY];
	assign io_mode  = ~ctrl_r[`MMBA_CTRL_PBUSN];

	// select line counts only with the resident strap high
	assign sel_ok   = res_mode ? sel_s : 1'b1;

	// peripheral mode asks only for memory cycles
	assign io_ok    = io_mode ? mem_cycle : 1'b1;

	// the current processor cycle needs the shared bus
	assign need_now = cycle_active & sel_ok & io_ok;

	// --------------------------------------------------------------
	// surrender conditions
	// --------------------------------------------------------------
	// common-request line: with yield-to-any the bus goes at cycle end,
	// otherwise only when the current cycle does not need it
	assign common_bus_request_n_yield = ~common_bus_request_n_n_s & common_request_lock_n_n_s
	                  & (any_mode ? ~cycle_active
	                              : (~need_now | halted));

	// a higher-priority master waits for the end of the present cycle
	assign pri_yield  = pri_n_s & ~cycle_active;

	// halt is the only voluntary release; lock overrides everything but initialisation
	assign surrender  = lock_n_s & (common_bus_request_n_yield | pri_yield | halted);

	// --------------------------------------------------------------
	// arbitration state machine
	// --------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (bclk_fall && need_now)
					state_nxt = ST_REQ;
			end
			ST_REQ: begin
				// priority granted and busy line free
				if (bclk_fall && !pri_n_s && busy_s)
					state_nxt = ST_OWN;
			end
			ST_OWN: begin
				if (bclk_fall && surrender)
					state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// initialisation takes the bus away at once
		if (!init_n_s)
			state_nxt = ST_IDLE;
	end

	// state and registered pin drivers
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= ST_IDLE;
			bus_request_out_n_n_r   <= 1'b1;
			aen_n_r    <= 1'b1;
			busy_drv_r <= 1'b0;
			common_bus_request_n_drv_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			// request stays low while requesting or owning
			bus_request_out_n_n_r   <= (state_nxt == ST_IDLE);
			// latches and controller drive only while we own the bus
			aen_n_r    <= (state_nxt != ST_OWN);
			busy_drv_r <= (state_nxt == ST_OWN);
			// only a waiting arbiter pulls the common line
			common_bus_request_n_drv_r <= (state_nxt == ST_REQ);
		end
	end

	assign bus_request_out_n      = bus_request_out_n_n_r;
	assign address_drive_enable_n = aen_n_r;
	assign busy_out               = 1'b0;
	assign busy_oe                = busy_drv_r;
	assign common_bus_request_out = 1'b0;
	assign common_bus_request_oe  = common_bus_request_n_drv_r;

	// --------------------------------------------------------------
	// bus grant counter
	// --------------------------------------------------------------
	// a grant in the clearing cycle still counts
	always @(posedge aclk) begin
		if (!aresetn)
			grant_cnt_r <= {CNT_W{1'b0}};
		else if (state_r == ST_REQ && state_nxt == ST_OWN)
			grant_cnt_r <= (wr_do && aw_addr_r == `MMBA_REG_COUNT) ?
			               {{(CNT_W-1){1'b0}}, 1'b1} : grant_cnt_r + 1'b1;
		else if (wr_do && aw_addr_r == `MMBA_REG_COUNT)
			grant_cnt_r <= {CNT_W{1'b0}};
	end

	// --------------------------------------------------------------
	// register bus, write side
	// --------------------------------------------------------------
	// address and data are held independently, in either order
	assign s_axi_awready = ~aw_full_r;
	assign s_axi_wready  = ~w_full_r;
	assign aw_take       = s_axi_awvalid & ~aw_full_r;
	assign w_take        = s_axi_wvalid & ~w_full_r;
	assign wr_do         = aw_full_r & w_full_r & ~bvalid_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_full_r  <= 1'b0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `MMBA_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			// both halves present: commit and answer
			if (wr_do) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				case (aw_addr_r)
					`MMBA_REG_CTRL,
					`MMBA_REG_STATUS,
					`MMBA_REG_COUNT: bresp_r <= `MMBA_RESP_OKAY;
					default:         bresp_r <= `MMBA_RESP_DECERR;
				endcase
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// control register; status writes are ignored
	always @(posedge aclk) begin
		if (!aresetn)
			ctrl_r <= `MMBA_CTRL_RST;
		else if (wr_do && aw_addr_r == `MMBA_REG_CTRL && w_strb_r[0])
			ctrl_r <= w_data_r[2:0];
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// --------------------------------------------------------------
	// register bus, read side
	// --------------------------------------------------------------
	// one read at a time; no new address until the data is taken
	assign s_axi_arready = ~rvalid_r;
	assign ar_take       = s_axi_arvalid & ~rvalid_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= `MMBA_RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rresp_r  <= `MMBA_RESP_OKAY;
			case (s_axi_araddr)
				`MMBA_REG_CTRL:
					rdata_r <= {29'h0, ctrl_r};
				`MMBA_REG_STATUS:
					rdata_r <= {23'h0, ~lock_n_s, halted, cycle_active,
					            common_bus_request_n_n_s, busy_s, aen_n_r, bus_request_out_n_n_r,
					            state_r[1], state_r[2]};
				`MMBA_REG_COUNT:
					rdata_r <= {{(32-CNT_W){1'b0}}, grant_cnt_r};
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= `MMBA_RESP_DECERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = rdata_r;
endmodule // mmba_top

// file: tb/mmba_peer.sv
// ----------
// peer arbiters on the shared bus
// ----------
module mmba_peer (
	output logic bus_clk,
	output logic busy_in,
	output logic common_bus_request_n,
	output logic priority_in_n,
	input  wire  busy_out,
	input  wire  busy_oe,
	input  wire  common_bus_request_out,
	input  wire  common_bus_request_oe,
	input  wire  peer_busy,
	input  wire  peer_req,
	input  wire  prio_ok
);
	timeunit 1ns;
	timeprecision 100ps;
	logic hold_r = 1'b0;
	logic ask_r  = 1'b0;
	logic prio_r = 1'b1;
	// bus clock runs free at eight system clock periods, each edge 0.7 ns before a system clock rise
	initial begin
		bus_clk = 1'b0;
		#1.3;
		forever #16 bus_clk = ~bus_clk;
	end
	// peers move lines on the rise, away from the fall the arbiter acts on
	always @(posedge bus_clk) begin
		hold_r <= peer_busy;
		ask_r  <= peer_req;
		prio_r <= !prio_ok;
	end
	// busy and common request are open-drain with pull-ups: any party pulling low wins; priority is driven directly
	assign busy_in = !((busy_oe && !busy_out) || hold_r);
	assign common_bus_request_n = !((common_bus_request_oe && !common_bus_request_out) || ask_r);
	assign priority_in_n = prio_r;
endmodule // mmba_peer

// file: tb/mmba_tb.sv
`include "mmba_consts.vh"

// ----------
// arbiter bench
// ----------
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  st = 3'h7;
	logic        common_request_lock_n = 1'b1, system_or_local_select = 1'b0;
	logic        bus_init_n = 1'b1, peer_busy = 1'b0, peer_req = 1'b0, prio_ok = 1'b1;
	logic        bus_clk, busy_in, busy_out, busy_oe, common_bus_request_n, priority_in_n;
	logic        common_bus_request_out, common_bus_request_oe;
	logic        bus_request_out_n, address_drive_enable_n;
	int          err_total = 0, checked = 0;

	// system clock, 4 ns
	always #2 aclk = ~aclk;
	mmba_top dut (.*, .s_axi_wstrb(4'hF), .proc_lock_n(1'b1), .status_bit_two(st[2]),
		.status_bit_one(st[1]), .status_bit_zero(st[0]));
	mmba_peer peer (.*);

	task automatic print_verdict;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	// bounded wait for ownership e; with hold, e must stand the whole time
	task automatic own(input logic e, input int n, input bit hold, input string m);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(negedge aclk);
			if (hold && busy_oe !== e)
				ok = 1'b0;
			if (!hold && busy_oe === e)
				break;
		end
		if (!hold)
			ok = busy_oe === e;
		if (!hold)
			chk({bus_request_out_n, address_drive_enable_n}, {!e, !e}, m);
		chk(ok, 1'b1, m);
		@(posedge aclk);
		if (!ok && !hold)
			print_verdict;
	endtask

	// one register access; each channel released as soon as it is taken
	task automatic ax(input bit w, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic       ka, kw, kr;
		logic [33:0] g;
		ka = 1'b1;
		kw = w;
		kr = 1'b1;
		g = 34'h0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		s_axi_bready <= w;
		s_axi_rready <= !w;
		for (int i = 0; i < 40 && kr; i++) begin
			@(negedge aclk);
			ka = ka && !(w ? s_axi_awready : s_axi_arready);
			kw = kw && !s_axi_wready;
			kr = !(w ? s_axi_bvalid : s_axi_rvalid);
			g = w ? {s_axi_bresp, d} : {s_axi_rresp, s_axi_rdata};
			@(posedge aclk);
			s_axi_awvalid <= w && ka;
			s_axi_wvalid <= kw;
			s_axi_arvalid <= !w && ka;
			s_axi_bready <= w && kr;
			s_axi_rready <= !w && kr;
		end
		@(posedge aclk);
		chk({kr, g}, {1'b0, er, d}, "register access");
		if (kr)
			print_verdict;
	endtask

	// reset value, unmapped place read and written
	task automatic t_regs;
		ax(0, `MMBA_REG_CTRL, 32'h4, `MMBA_RESP_OKAY);
		ax(0, 8'h0C, 32'h0, `MMBA_RESP_DECERR);
		ax(1, 8'h0C, 32'h1, `MMBA_RESP_DECERR);
	endtask

	// busy held by a peer or missing priority blocks the grant; halt gives the bus back
	task automatic t_acq;
		peer_busy <= 1'b1;
		st <= 3'h5;
		own(0, 40, 1, "grant while busy");
		peer_busy <= 1'b0;
		// busy line frees and priority goes away on the same bus clock rise
		prio_ok <= 1'b0;
		own(0, 40, 1, "grant without priority");
		prio_ok <= 1'b1;
		own(1, 40, 0, "no grant");
		ax(0, `MMBA_REG_COUNT, 32'h1, `MMBA_RESP_OKAY);
		// owning, busy pulled, common line free, memory cycle active
		ax(0, `MMBA_REG_STATUS, 32'h61, `MMBA_RESP_OKAY);
		ax(1, `MMBA_REG_COUNT, 32'h0, `MMBA_RESP_OKAY);
		ax(0, `MMBA_REG_COUNT, 32'h0, `MMBA_RESP_OKAY);
		st <= `MMBA_ST_HALT;
		own(0, 40, 0, "kept in halt");
		st <= `MMBA_ST_PASSIVE;
	endtask

	// common request ignored under lock, honoured after it
	task automatic t_lock;
		st <= 3'h5;
		own(1, 40, 0, "no grant");
		st <= `MMBA_ST_PASSIVE;
		common_request_lock_n <= 1'b0;
		peer_req <= 1'b1;
		own(1, 40, 1, "yield under lock");
		common_request_lock_n <= 1'b1;
		own(0, 40, 0, "kept after lock");
		peer_req <= 1'b0;
	endtask

	// yield to any with the common line held low: give up after each cycle
	task automatic t_any;
		ax(1, `MMBA_REG_CTRL, 32'h6, `MMBA_RESP_OKAY);
		peer_req <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			st <= 3'h5;
			own(1, 40, 0, "no grant");
			own(1, 24, 1, "yield mid cycle");
			st <= `MMBA_ST_PASSIVE;
			own(0, 40, 0, "kept after cycle");
		end
		peer_req <= 1'b0;
	endtask

	// resident mode follows the select input; off, the select is ignored
	task automatic t_res;
		ax(1, `MMBA_REG_CTRL, 32'h5, `MMBA_RESP_OKAY);
		st <= 3'h5;
		own(0, 40, 1, "grant with select low");
		system_or_local_select <= 1'b1;
		own(1, 40, 0, "no grant with select high");
		system_or_local_select <= 1'b0;
		peer_req <= 1'b1;
		own(0, 40, 0, "kept with select low");
		peer_req <= 1'b0;
		ax(1, `MMBA_REG_CTRL, 32'h4, `MMBA_RESP_OKAY);
		own(1, 40, 0, "select not ignored");
		st <= `MMBA_ST_HALT;
		own(0, 40, 0, "kept in halt");
		st <= `MMBA_ST_PASSIVE;
	endtask

	// peripheral mode: io and interrupt acknowledge do not ask for the bus
	task automatic t_pbus;
		ax(1, `MMBA_REG_CTRL, 32'h0, `MMBA_RESP_OKAY);
		st <= 3'h1;
		own(0, 40, 1, "grant for io");
		st <= 3'h0;
		own(0, 40, 1, "grant for int ack");
		st <= 3'h5;
		own(1, 40, 0, "no grant for memory");
		st <= 3'h1;
		peer_req <= 1'b1;
		own(0, 40, 0, "kept during io");
		peer_req <= 1'b0;
		st <= `MMBA_ST_PASSIVE;
		ax(1, `MMBA_REG_CTRL, 32'h4, `MMBA_RESP_OKAY);
	endtask

	// bus initialise drops ownership
	task automatic t_init;
		st <= 3'h5;
		own(1, 40, 0, "no grant");
		bus_init_n <= 1'b0;
		own(0, 40, 0, "kept through init");
		st <= `MMBA_ST_PASSIVE;
		repeat (8) @(posedge aclk);
		bus_init_n <= 1'b1;
		repeat (16) @(posedge aclk);
	endtask

	// reset held four cycles; the synchronisers reset every pin to high
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_acq;
		t_lock;
		t_any;
		t_res;
		t_pbus;
		t_init;
		print_verdict;
	end
endmodule // testbench

bind mmba_top mmba_top_chk mon (.*);

// file: tb/mmba_top_asserts.sv
// ----------
// port checker
// ----------
module mmba_top_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bus_init_n,
	input wire logic priority_in_n,
	input wire logic bus_request_out_n,
	input wire logic address_drive_enable_n,
	input wire logic busy_out,
	input wire logic busy_oe,
	input wire logic common_bus_request_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// latches may drive only while we own the bus
	aen_own_a: assert property (address_drive_enable_n == !busy_oe)
		else $error("aen off ownership");
	// an owner keeps its request low until it gives up
	req_held_a: assert property (busy_oe |-> !bus_request_out_n)
		else $error("owner lost request");
	// the owner never pulls the common request line
	cbr_quiet_a: assert property (busy_oe |-> !common_bus_request_oe)
		else $error("owner pulls common line");
	// nine low samples cover sync, filter and output stage
	init_idle_a: assert property (!bus_init_n [*8] ##1 !bus_init_n |->
		!busy_oe && bus_request_out_n)
		else $error("init left bus owned");
	// a grant only follows a pending request
	grant_seq_a: assert property ($rose(busy_oe) |->
		$past(common_bus_request_oe) && !$past(bus_request_out_n))
		else $error("grant without request");
	prio_seen_a: assert property ($rose(busy_oe) |-> !$past(priority_in_n, 4))
		else $error("grant without priority");
	give_up_a: assert property ($fell(busy_oe) |-> bus_request_out_n)
		else $error("request kept on surrender");
	busy_pull_a: assert property (busy_oe |-> !busy_out)
		else $error("busy not pulled low");
	cover property ($rose(busy_oe));
	cover property ($fell(busy_oe));
	cover property ($rose(common_bus_request_oe));
endmodule // mmba_top_chk
